// file: verification/rtiu_chk_assertions.sv
// Return unit checker
module rtiu_chk(input logic core_clk, sys_rst, stackPop, flushFetch,
  globalIrqEnableSet, workingLoad, busy, cycleStrobe,
  input logic [13:0] instrWord,
  input logic [12:0] stackTop, programCounter, input logic [7:0] workingReg);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_pop_pc: assert property (stackPop |->
    programCounter == $past(stackTop)) else $error("pc");
  a_irq_set: assert property (stackPop |->
    globalIrqEnableSet == ($past(instrWord) == 14'h0009)) else $error("ie");
  a_irq_only: assert property (globalIrqEnableSet |-> stackPop)
    else $error("ie alone");
  a_ret_len: assert property (stackPop |-> ##4 flushFetch)
    else $error("len");
  a_keep_w: assert property (!workingLoad |-> $stable(workingReg))
    else $error("w");
  a_plain_keep: assert property (stackPop &&
    $past(instrWord) == 14'h0008 |-> !workingLoad && !globalIrqEnableSet)
    else $error("plain");
  a_lit_load: assert property (workingLoad |-> stackPop &&
    workingReg == $past(instrWord[7:0])) else $error("lit");
  a_cyc_period: assert property (cycleStrobe |-> ##4 cycleStrobe)
    else $error("cycle");
  a_flush_end: assert property (flushFetch |-> !busy && $past(busy))
    else $error("flush");
endmodule // rtiu_chk
bind rtiu_return_unit rtiu_chk u_rtiu_chk(.*);

// file: verification/tb_top.sv
// Return unit bench
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, sys_rst = 1, instrValid = 0, stackPop, pcLoad, busy;
  logic flushFetch, globalIrqEnableSet, workingLoad, cycleStrobe;
  logic [13:0] instrWord = 14'h0000;
  logic [12:0] stackTop = 13'h0000, programCounter;
  logic [7:0] workingReg;
  wire [21:0] got = {programCounter, workingReg, flushFetch};
  int err_total = 0, num_checks = 0, n;
  rtiu_return_unit u_rtiu_return_unit(.*);
  initial forever #5 core_clk = ~core_clk;
  task test_done;
    $display("%0d checks %0d errors", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task ret(input [13:0] w, input [12:0] t, input [7:0] ew, input el, ei);
    @(negedge core_clk);
    instrWord = w;
    stackTop = t;
    instrValid = 1'h1;
    for (n = 0; n < 9 && stackPop !== 1'h1; n++) @(negedge core_clk);
    instrValid = 1'h0;
    if (n == 9) begin
      err_total++;
      $display("[ERR] %0t no pop for %h", $time, w);
      test_done;
    end
    num_checks++;
    if ({pcLoad, workingLoad, globalIrqEnableSet, busy} !== {1'h1, el, ei, 1'h1})
    begin
      err_total++;
      $display("[ERR] %0t bad pulses %h", $time, w);
    end
    repeat (4) @(negedge core_clk);
    num_checks++;
    if (got !== {t, ew, 1'h1} || {cycleStrobe, busy} !== 2'h2) begin
      err_total++;
      $display("[ERR] %0t bad return %h", $time, w);
    end
    $display("return %h done", w);
  endtask
  task noret(input [13:0] w);
    @(negedge core_clk);
    instrWord = w;
    instrValid = 1'h1;
    for (n = 0; n < 8; n++) begin
      @(negedge core_clk);
      num_checks++;
      if (stackPop !== 1'h0 || busy !== 1'h0) begin
        err_total++;
        $display("[ERR] %0t word %h taken as return", $time, w);
      end
    end
    instrValid = 1'h0;
    $display("non-return %h done", w);
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    sys_rst = 1'h0;
    ret(14'h0009, 13'h1ABC, 8'h00, 1'h0, 1'h1);
    ret(14'h37FF, 13'h1FFF, 8'hFF, 1'h1, 1'h0);
    ret(14'h0008, 13'h0001, 8'hFF, 1'h0, 1'h0);
    ret(14'h3400, 13'h0000, 8'h00, 1'h1, 1'h0);
    noret(14'h000A);
    test_done;
  end
endmodule // tb_top

// file: verilog/rtiu_regs.vh
// Constants for the return instruction unit
`ifndef RTIU_REGS_VH
`define RTIU_REGS_VH
`define RTIU_OP_RETURN       14'h0008
`define RTIU_OP_RETFROMINT   14'h0009
`define RTIU_LIT_OP_MASK     14'h3C00
`define RTIU_LIT_OP_CODE     14'h3400
`define RTIU_PHASES_PER_CYC  4
`define RTIU_LAST_PHASE      2'h3
`define RTIU_RET_CYCLES      2
`define RTIU_PC_RESET        13'h0000
`define RTIU_W_RESET         8'h00
`endif

// file: verilog/rtiu_return_unit.v
// Return instruction execution unit: pops stack into PC, updates W and IRQ
`include "rtiu_regs.vh"
module rtiu_return_unit (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire [13:0] instrWord,
  input  wire        instrValid,
  input  wire [12:0] stackTop,
  output reg         stackPop,
  output reg  [12:0] programCounter,
  output reg         pcLoad,
  output reg  [7:0]  workingReg,
  output reg         workingLoad,
  output reg         globalIrqEnableSet,
  output reg         flushFetch,
  output reg         busy,
  output reg         cycleStrobe
);

  // Sequencer states
  localparam ST_IDLE   = 2'h0;
  localparam ST_SECOND = 2'h1;

  // Phase within the current instruction cycle
  reg  [1:0] phase;
  reg  [1:0] state;
  reg  [1:0] next_phase;
  reg  [1:0] next_state;
  reg  [7:0] litField;

  // Decode and sequencing qualifiers
  reg        cycEnd;
  reg        isPlainRet;
  reg        isIntRet;
  reg        isLitRet;
  reg        isAnyRet;
  reg        acceptRet;
  reg        secondEnd;

  // Decode from a single program word; no status flag path exists here
  always @* begin
    isPlainRet = (instrWord == `RTIU_OP_RETURN);
    isIntRet   = (instrWord == `RTIU_OP_RETFROMINT);
    isLitRet   = ((instrWord & `RTIU_LIT_OP_MASK) == `RTIU_LIT_OP_CODE);
    isAnyRet   = isPlainRet | isIntRet | isLitRet;
    litField   = instrWord[7:0];
  end

  // Last of the four phases closes an instruction cycle
  always @* begin
    cycEnd = (phase == `RTIU_LAST_PHASE);
  end

  // Words are only looked at on a cycle boundary while idle
  always @* begin
    acceptRet = cycEnd && (state == ST_IDLE) && instrValid && isAnyRet;
    secondEnd = cycEnd && (state == ST_SECOND);
  end

  always @* begin
    next_phase = phase + 2'h1;
  end

  always @* begin
    next_state = state;
    if (acceptRet) begin
      next_state = ST_SECOND;
    end else if (secondEnd) begin
      next_state = ST_IDLE;
    end
  end

  // Free-running phase counter, so cycles are fixed four-clock slots
  always @(posedge core_clk) begin
    if (sys_rst) begin
      phase <= 2'h0;
    end else begin
      phase <= next_phase;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Cycle boundary marker, one clock after the last phase
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cycleStrobe <= 1'h0;
    end else begin
      cycleStrobe <= cycEnd;
    end
  end

  // Pop request: one pulse per accepted return
  always @(posedge core_clk) begin
    if (sys_rst) begin
      stackPop <= 1'h0;
    end else if (acceptRet) begin
      stackPop <= 1'h1;
    end else begin
      stackPop <= 1'h0;
    end
  end

  // Return address taken from the stack top
  always @(posedge core_clk) begin
    if (sys_rst) begin
      programCounter <= `RTIU_PC_RESET;
    end else if (acceptRet) begin
      programCounter <= stackTop;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      pcLoad <= 1'h0;
    end else if (acceptRet) begin
      pcLoad <= 1'h1;
    end else begin
      pcLoad <= 1'h0;
    end
  end

  // Working register changes only on a literal return
  always @(posedge core_clk) begin
    if (sys_rst) begin
      workingReg <= `RTIU_W_RESET;
    end else if (acceptRet && isLitRet) begin
      workingReg <= litField;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      workingLoad <= 1'h0;
    end else if (acceptRet && isLitRet) begin
      workingLoad <= 1'h1;
    end else begin
      workingLoad <= 1'h0;
    end
  end

  // Enable is set, never cleared, by the interrupt return
  always @(posedge core_clk) begin
    if (sys_rst) begin
      globalIrqEnableSet <= 1'h0;
    end else if (acceptRet && isIntRet) begin
      globalIrqEnableSet <= 1'h1;
    end else begin
      globalIrqEnableSet <= 1'h0;
    end
  end

  // Prefetched word is dropped as the second cycle ends
  always @(posedge core_clk) begin
    if (sys_rst) begin
      flushFetch <= 1'h0;
    end else if (secondEnd) begin
      flushFetch <= 1'h1;
    end else begin
      flushFetch <= 1'h0;
    end
  end

  // Busy spans the second instruction cycle
  always @(posedge core_clk) begin
    if (sys_rst) begin
      busy <= 1'h0;
    end else begin
      busy <= (next_state == ST_SECOND);
    end
  end

endmodule // rtiu_return_unit
